//--- tcl_defs.vh
// Constants for the thermal control and limit register bank.
// Assumes byte-wide registers reached by command byte over the serial bus.
`ifndef TCL_DEFS_VH
`define TCL_DEFS_VH

// Command byte of each register
`define TCL_OFS_STATUS   8'h02
`define TCL_OFS_CONFIG   8'h03
`define TCL_OFS_MASK     8'h04
`define TCL_OFS_LHI      8'h05
`define TCL_OFS_LLO      8'h06
`define TCL_OFS_RHI      8'h07

// Power-up and warm-reset values
`define TCL_RST_CONFIG   8'h80
`define TCL_RST_MASK     8'h07
`define TCL_RST_LHI      8'h3c
`define TCL_RST_LLO      8'h00
`define TCL_RST_RHI      8'h50
`define TCL_RST_STATUS   8'h00

// Control settings fields
`define TCL_CFG_IE       7
`define TCL_CFG_SLEEP_SELECT     6
`define TCL_CFG_FQ_HI    5
`define TCL_CFG_FQ_LO    4
`define TCL_CFG_RES_HI   3
`define TCL_CFG_RES_LO   2
`define TCL_CFG_RSVD     1
`define TCL_CFG_RST      0

// Event bit positions, shared by status and mask
`define TCL_EV_READY     7
`define TCL_EV_LHI       6
`define TCL_EV_LLO       5
`define TCL_EV_RHI       4
`define TCL_EV_RLO       3
`define TCL_EV_DIODE     2
`define TCL_EV_RCRIT     1
`define TCL_EV_LCRIT     0

// Lock bit positions
`define TCL_LK_LCRIT     0
`define TCL_LK_RCRIT     1
`define TCL_LK_DIODE     2
`define TCL_LK_SLEEP     3
`define TCL_LK_WARM      4

// Fault queue depths per two-bit code
`define TCL_FQ_CODE0     2'h0
`define TCL_FQ_CODE1     2'h1
`define TCL_FQ_CODE2     2'h2
`define TCL_FQ_DEPTH0    3'h1
`define TCL_FQ_DEPTH1    3'h2
`define TCL_FQ_DEPTH2    3'h4
`define TCL_FQ_DEPTH3    3'h6

// Bits per byte on the serial bus
`define TCL_BYTE_BITS    4'h8

`endif

//--- tcl_smb.v
// Byte-level slave of the two-wire management bus: address, command, data.
// Assumes raw pin levels on scl_in and sda_in; the bus clock is far slower than clk.
`timescale 1ns/1ps
`default_nettype none
`include "tcl_defs.vh"

module tcl_smb #(
    parameter [6:0] DEV_ADDR = 7'h2a        // Arbitrary bus address
) (
    input  wire       clk,                  // System clock
    input  wire       arst_n,               // Asynchronous reset, active low
    input  wire       scl_in,               // Bus clock pin level
    input  wire       sda_in,               // Bus data pin level
    output reg        sda_out,              // Data pin drive value, always low
    output reg        sda_oe,               // Pull data pin low while high
    input  wire [7:0] rd_data,              // Register value at the pointer
    output reg  [7:0] ptr,                  // Command byte last received
    output reg        wr_stb,               // One-cycle pulse, byte written
    output reg  [7:0] wr_data,              // Byte written
    output reg        rd_stb                // One-cycle pulse, byte sent
);

    localparam [2:0] S_IDLE = 3'h0;
    localparam [2:0] S_ADDR = 3'h1;
    localparam [2:0] S_CMD  = 3'h2;
    localparam [2:0] S_WDAT = 3'h3;
    localparam [2:0] S_ACK  = 3'h4;
    localparam [2:0] S_RDAT = 3'h5;
    localparam [2:0] S_MACK = 3'h6;

    reg       scl_s1, scl_s2, scl_d;
    reg       sda_s1, sda_s2, sda_d;
    reg [2:0] st_r;
    reg [2:0] after_r;
    reg [3:0] cnt_r;
    reg [7:0] sh_r;
    reg       mack_r;

    wire scl_rise = scl_s2 & ~scl_d;
    wire scl_fall = ~scl_s2 & scl_d;
    wire bus_start = scl_s2 & scl_d & sda_d & ~sda_s2;
    wire bus_stop  = scl_s2 & scl_d & ~sda_d & sda_s2;

    // Two-flop synchronisers, then one delay stage for edge finding
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            scl_s1 <= 1'b1;
            scl_s2 <= 1'b1;
            scl_d  <= 1'b1;
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
            sda_d  <= 1'b1;
        end else begin
            scl_s1 <= scl_in;
            scl_s2 <= scl_s1;
            scl_d  <= scl_s2;
            sda_s1 <= sda_in;
            sda_s2 <= sda_s1;
            sda_d  <= sda_s2;
        end
    end

    // Transfer sequencer; data changes only on falling bus clock
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r    <= S_IDLE;
            after_r <= S_IDLE;
            cnt_r   <= 4'h0;
            sh_r    <= 8'h00;
            mack_r  <= 1'b0;
            sda_out <= 1'b0;
            sda_oe  <= 1'b0;
            ptr     <= 8'h00;
            wr_stb  <= 1'b0;
            wr_data <= 8'h00;
            rd_stb  <= 1'b0;
        end else begin
            wr_stb <= 1'b0;
            rd_stb <= 1'b0;
            sda_out <= 1'b0;                // Open drain: only ever pulls low
            if (bus_start) begin
                st_r   <= S_ADDR;
                cnt_r  <= 4'h0;
                sda_oe <= 1'b0;
            end else if (bus_stop) begin
                st_r   <= S_IDLE;
                sda_oe <= 1'b0;
            end else begin
                case (st_r)
                    S_ADDR, S_CMD, S_WDAT: begin
                        if (scl_rise && cnt_r != `TCL_BYTE_BITS) begin
                            sh_r  <= {sh_r[6:0], sda_s2};
                            cnt_r <= cnt_r + 4'h1;
                        end else if (scl_fall && cnt_r == `TCL_BYTE_BITS) begin
                            cnt_r  <= 4'h0;
                            st_r   <= S_ACK;
                            sda_oe <= 1'b1;
                            if (st_r == S_ADDR) begin
                                if (sh_r[7:1] != DEV_ADDR) begin
                                    st_r   <= S_IDLE;
                                    sda_oe <= 1'b0;
                                end
                                after_r <= sh_r[0] ? S_RDAT : S_CMD;
                            end else if (st_r == S_CMD) begin
                                ptr     <= sh_r;
                                after_r <= S_WDAT;
                            end else begin
                                wr_stb  <= 1'b1;
                                wr_data <= sh_r;
                                after_r <= S_IDLE;
                            end
                        end
                    end
                    S_ACK, S_MACK: begin
                        if (scl_rise) begin
                            mack_r <= ~sda_s2;
                        end
                        if (scl_fall) begin
                            if ((st_r == S_ACK && after_r == S_RDAT) ||
                                (st_r == S_MACK && mack_r)) begin
                                sh_r   <= rd_data;
                                sda_oe <= ~rd_data[7];
                                rd_stb <= 1'b1;
                                cnt_r  <= 4'h1;
                                st_r   <= S_RDAT;
                            end else begin
                                sda_oe <= 1'b0;
                                st_r   <= (st_r == S_ACK) ? after_r : S_IDLE;
                            end
                        end
                    end
                    S_RDAT: begin
                        if (scl_fall) begin
                            if (cnt_r == `TCL_BYTE_BITS) begin
                                sda_oe <= 1'b0;
                                mack_r <= 1'b0;
                                st_r   <= S_MACK;
                            end else begin
                                sda_oe <= ~sh_r[6];
                                sh_r   <= {sh_r[6:0], 1'b0};
                                cnt_r  <= cnt_r + 4'h1;
                            end
                        end
                    end
                    default: begin
                        sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end

endmodule // tcl_smb

`default_nettype wire

//--- tcl_regs.v
// Control, mask and limit registers of a two-zone temperature supervisor.
// Assumes a converter on clk that pulses conv_done with fresh results, and lock
// bits held by a separate lock register on the same clock.
//
// Overview of operation
// - Control bit 7 enables interrupt signalling when 1.
// - Control bit 6 set puts the device in shutdown.
// - Queue depth code 00,01,10,11 gives 1,2,4,6 consecutive faults.
// - Resolution code selects 9 to 12 bits; drives the converter.
// - Writing 1 to control bit 0 performs a warm reset to defaults.
// - Warm restart lockout makes writes of the restart bit ignored.
// - Control register resets to 0x80.
// - Any control write purges every fault queue.
// - Any control write aborts the running conversion and drops its result.
// - After a control write a fresh conversion sequence starts.
// - Mask register has one enable bit per event source.
// - Mask register resets to 0x07.
// - Local upper limit is read/write, resets to 0x3c.
// - Local lower limit is read/write, resets to 0x00.
// - Remote upper limit high byte is read/write, resets to 0x50.
// - Limits are two's complement, one degree per bit.
// - A limit write purges that limit's fault queue.
// - Status holds ready and event flags; reading it clears them.
// - Critical locks force their own mask bit (0 local, 1 remote) and interrupt enable on.
// - Sleep lockout blocks shutdown and leaves shutdown at once.
`timescale 1ns/1ps
`default_nettype none
`include "tcl_defs.vh"

module tcl_regs #(
    parameter [6:0] DEV_ADDR = 7'h2a        // Arbitrary bus address
) (
    input  wire       clk,                  // System clock, 50 MHz
    input  wire       arst_n,               // Asynchronous reset, active low
    input  wire       scl_in,               // Bus clock pin
    input  wire       sda_in,               // Bus data pin level
    output wire       sda_out,              // Bus data drive value
    output wire       sda_oe,               // Bus data drive enable
    output reg        int_out,              // Interrupt pin drive value, low
    output reg        int_oe,               // Interrupt pin pulled low
    input  wire [4:0] lock_bits,            // Lock register bits
    input  wire       conv_done,            // Conversion finished pulse
    input  wire [7:0] local_temp,           // Local result, whole degrees
    input  wire [7:0] remote_temp,          // Remote result, high byte
    input  wire       remote_low_trip,      // Remote below low limit
    input  wire       diode_fault,          // Remote diode fault
    input  wire       local_crit_trip,      // Local over-temperature
    input  wire       remote_crit_trip,     // Remote over-temperature
    output reg        sleep_select,         // Shutdown request
    output reg  [1:0] adc_bit_width_sel,    // Remote resolution code
    output reg        conv_abort,           // Abort conversion pulse
    output reg        conv_start,           // Start conversion pulse
    output reg        warm_reset            // Warm reset pulse to others
);

    reg        irq_global_enable;
    reg  [1:0] trip_queue_depth;
    reg  [7:0] event_enable_mask;
    reg  [7:0] local_upper_limit;
    reg  [7:0] local_lower_limit;
    reg  [7:0] remote_upper_limit_msb;
    reg  [7:0] status_r;
    reg  [2:0] q_lhi_r;
    reg  [2:0] q_llo_r;
    reg  [2:0] q_rhi_r;
    reg  [7:0] rd_mux;
    reg  [7:0] ev_set;
    wire [7:0] ptr;
    wire       wr_stb;
    wire [7:0] wr_data;
    wire       rd_stb;

    // Control power-up value, sliced per field for both resets
    localparam [7:0] CFG_DFLT = `TCL_RST_CONFIG;

    // Queue depth decoding
    function [2:0] fq_depth;
        input [1:0] code;
        begin
            case (code)
                `TCL_FQ_CODE0: fq_depth = `TCL_FQ_DEPTH0;
                `TCL_FQ_CODE1: fq_depth = `TCL_FQ_DEPTH1;
                `TCL_FQ_CODE2: fq_depth = `TCL_FQ_DEPTH2;
                default:       fq_depth = `TCL_FQ_DEPTH3;
            endcase
        end
    endfunction

    // Consecutive fault count, saturating at the depth
    function [2:0] q_step;
        input [2:0] cnt;
        input       fault;
        input [2:0] depth;
        begin
            if (!fault)
                q_step = 3'h0;
            else if (cnt >= depth)
                q_step = depth;
            else
                q_step = cnt + 3'h1;
        end
    endfunction

    // Serial bus slave
    tcl_smb #(
        .DEV_ADDR (DEV_ADDR)
    ) u_smb (
        .clk     (clk),
        .arst_n  (arst_n),
        .scl_in  (scl_in),
        .sda_in  (sda_in),
        .sda_out (sda_out),
        .sda_oe  (sda_oe),
        .rd_data (rd_mux),
        .ptr     (ptr),
        .wr_stb  (wr_stb),
        .wr_data (wr_data),
        .rd_stb  (rd_stb)
    );

    // Write decode and lock qualifiers
    wire wr_cfg   = wr_stb && (ptr == `TCL_OFS_CONFIG);
    wire wr_mask  = wr_stb && (ptr == `TCL_OFS_MASK);
    wire wr_lhi   = wr_stb && (ptr == `TCL_OFS_LHI);
    wire wr_llo   = wr_stb && (ptr == `TCL_OFS_LLO);
    wire wr_rhi   = wr_stb && (ptr == `TCL_OFS_RHI);
    wire rd_stat  = rd_stb && (ptr == `TCL_OFS_STATUS);
    wire lk_lcrit = lock_bits[`TCL_LK_LCRIT];
    wire lk_rcrit = lock_bits[`TCL_LK_RCRIT];
    wire lk_diode = lock_bits[`TCL_LK_DIODE];
    wire lk_sleep = lock_bits[`TCL_LK_SLEEP];
    wire lk_warm  = lock_bits[`TCL_LK_WARM];
    wire do_warm  = wr_cfg && wr_data[`TCL_CFG_RST] && !lk_warm;

    // A result landing while the conversion is aborted is dropped
    wire conv_ok  = conv_done && !wr_cfg && !conv_abort;

    wire [2:0] depth = fq_depth(trip_queue_depth);
    wire lhi_fault = $signed(local_temp) > $signed(local_upper_limit);
    wire llo_fault = $signed(local_temp) < $signed(local_lower_limit);
    wire rhi_fault = $signed(remote_temp) > $signed(remote_upper_limit_msb);
    wire [2:0] lhi_nxt = q_step(q_lhi_r, lhi_fault, depth);
    wire [2:0] llo_nxt = q_step(q_llo_r, llo_fault, depth);
    wire [2:0] rhi_nxt = q_step(q_rhi_r, rhi_fault, depth);

    // Events raised by this conversion
    always @* begin
        ev_set = 8'h00;
        if (conv_ok) begin
            ev_set[`TCL_EV_READY] = 1'b1;
            ev_set[`TCL_EV_LHI]   = lhi_fault && (lhi_nxt == depth);
            ev_set[`TCL_EV_LLO]   = llo_fault && (llo_nxt == depth);
            ev_set[`TCL_EV_RHI]   = rhi_fault && (rhi_nxt == depth);
            ev_set[`TCL_EV_RLO]   = remote_low_trip;
            ev_set[`TCL_EV_DIODE] = diode_fault;
            ev_set[`TCL_EV_RCRIT] = remote_crit_trip;
            ev_set[`TCL_EV_LCRIT] = local_crit_trip;
        end
    end

    // Register read multiplexer; unmapped commands read zero
    always @* begin
        case (ptr)
            `TCL_OFS_STATUS: rd_mux = status_r;
            `TCL_OFS_CONFIG: rd_mux = {irq_global_enable, sleep_select,
                                       trip_queue_depth, adc_bit_width_sel,
                                       2'h0};
            `TCL_OFS_MASK:   rd_mux = event_enable_mask;
            `TCL_OFS_LHI:    rd_mux = local_upper_limit;
            `TCL_OFS_LLO:    rd_mux = local_lower_limit;
            `TCL_OFS_RHI:    rd_mux = remote_upper_limit_msb;
            default:         rd_mux = 8'h00;
        endcase
    end

    // Control settings, mask and limits; warm reset restores defaults
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_global_enable      <= CFG_DFLT[`TCL_CFG_IE];
            sleep_select           <= CFG_DFLT[`TCL_CFG_SLEEP_SELECT];
            trip_queue_depth       <= CFG_DFLT[`TCL_CFG_FQ_HI:`TCL_CFG_FQ_LO];
            adc_bit_width_sel      <= CFG_DFLT[`TCL_CFG_RES_HI:`TCL_CFG_RES_LO];
            event_enable_mask      <= `TCL_RST_MASK;
            local_upper_limit      <= `TCL_RST_LHI;
            local_lower_limit      <= `TCL_RST_LLO;
            remote_upper_limit_msb <= `TCL_RST_RHI;
        end else if (do_warm) begin
            irq_global_enable      <= CFG_DFLT[`TCL_CFG_IE];
            sleep_select           <= CFG_DFLT[`TCL_CFG_SLEEP_SELECT];
            trip_queue_depth       <= CFG_DFLT[`TCL_CFG_FQ_HI:`TCL_CFG_FQ_LO];
            adc_bit_width_sel      <= CFG_DFLT[`TCL_CFG_RES_HI:`TCL_CFG_RES_LO];
            event_enable_mask      <= `TCL_RST_MASK;
            local_upper_limit      <= `TCL_RST_LHI;
            local_lower_limit      <= `TCL_RST_LLO;
            remote_upper_limit_msb <= `TCL_RST_RHI;
        end else begin
            if (wr_cfg) begin
                irq_global_enable <= wr_data[`TCL_CFG_IE];
                sleep_select      <= wr_data[`TCL_CFG_SLEEP_SELECT];
                trip_queue_depth  <= wr_data[`TCL_CFG_FQ_HI:`TCL_CFG_FQ_LO];
                adc_bit_width_sel <= wr_data[`TCL_CFG_RES_HI:`TCL_CFG_RES_LO];
            end
            if (lk_lcrit || lk_rcrit || (lk_diode && event_enable_mask[`TCL_EV_DIODE]))
                irq_global_enable <= 1'b1;
            if (lk_sleep)
                sleep_select <= 1'b0;
            if (wr_mask) begin
                event_enable_mask <= wr_data;
                if (lk_diode)
                    event_enable_mask[`TCL_EV_DIODE] <=
                        event_enable_mask[`TCL_EV_DIODE];
            end
            if (lk_lcrit)
                event_enable_mask[`TCL_EV_LCRIT] <= 1'b1;
            if (lk_rcrit)
                event_enable_mask[`TCL_EV_RCRIT] <= 1'b1;
            if (wr_lhi)
                local_upper_limit <= wr_data;
            if (wr_llo)
                local_lower_limit <= wr_data;
            if (wr_rhi)
                remote_upper_limit_msb <= wr_data;
        end
    end

    // Fault queues: purged by control writes and their own limit write
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q_lhi_r <= 3'h0;
            q_llo_r <= 3'h0;
            q_rhi_r <= 3'h0;
        end else if (wr_cfg) begin
            q_lhi_r <= 3'h0;
            q_llo_r <= 3'h0;
            q_rhi_r <= 3'h0;
        end else begin
            if (wr_lhi)
                q_lhi_r <= 3'h0;
            else if (conv_ok)
                q_lhi_r <= lhi_nxt;
            if (wr_llo)
                q_llo_r <= 3'h0;
            else if (conv_ok)
                q_llo_r <= llo_nxt;
            if (wr_rhi)
                q_rhi_r <= 3'h0;
            else if (conv_ok)
                q_rhi_r <= rhi_nxt;
        end
    end

    // Sticky status; a new event wins over the read clear
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            status_r <= `TCL_RST_STATUS;
        else if (do_warm)
            status_r <= `TCL_RST_STATUS;
        else if (rd_stat)
            status_r <= ev_set;
        else
            status_r <= status_r | ev_set;
    end

    // Interrupt pin, converter sequencing and warm reset pulse
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            int_out    <= 1'b0;
            int_oe     <= 1'b0;
            conv_abort <= 1'b0;
            conv_start <= 1'b0;
            warm_reset <= 1'b0;
        end else begin
            int_out    <= 1'b0;
            int_oe     <= irq_global_enable &&
                          (|(status_r & event_enable_mask));
            conv_abort <= wr_cfg;
            conv_start <= conv_abort;
            warm_reset <= do_warm;
        end
    end

endmodule // tcl_regs

`default_nettype wire

//--- tcl_host.sv
// Bus host model: byte writes and reads on the two-wire management bus.
// Assumes the bench resolves the open-drain data line with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module tcl_host #(parameter logic [6:0] ADDR = 7'h2a) (
    input  wire logic clk,     // System clock
    input  wire logic sda,     // Resolved data line
    output var  logic scl,     // Bus clock, high when idle
    output var  logic sda_low  // Pulls data low while high
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // Half bus period, 80 ns
    task automatic hp();
        repeat (4) @(posedge clk);
    endtask
    // Start or repeated start; data moves a cycle after scl falls
    task automatic st();
        @(posedge clk) sda_low <= 1'b0;
        hp();
        scl <= 1'b1;
        hp();
        sda_low <= 1'b1;
        hp();
        scl <= 1'b0;
    endtask
    task automatic sp();
        @(posedge clk) sda_low <= 1'b1;
        hp();
        scl <= 1'b1;
        hp();
        sda_low <= 1'b0;
        hp();
    endtask
    // Eight bits MSB first, then a released ninth bit
    task automatic xb(input logic [7:0] d, output logic [7:0] q, output logic ack);
        logic [8:0] v;
        v = {d, 1'b1};
        for (int i = 0; i < 9; i++) begin
            @(posedge clk) sda_low <= !v[8-i];
            hp();
            scl <= 1'b1;
            hp();
            if (i < 8) q[7-i] = sda;
            else ack = !sda;
            scl <= 1'b0;
        end
    endtask
    task automatic wr(input logic [7:0] c, d, output logic ok);
        logic [7:0] q;
        logic a0, a1, a2;
        st();
        xb({ADDR, 1'b0}, q, a0);
        xb(c, q, a1);
        xb(d, q, a2);
        sp();
        ok = a0 & a1 & a2;
    endtask
    // Read ends with a host NACK
    task automatic rd(input logic [7:0] c, output logic [7:0] q, output logic ok);
        logic a0, a1, a2, n;
        st();
        xb({ADDR, 1'b0}, q, a0);
        xb(c, q, a1);
        st();
        xb({ADDR, 1'b1}, q, a2);
        xb(8'hff, q, n);
        sp();
        ok = a0 & a1 & a2 & !n;
    endtask
endmodule // tcl_host
`default_nettype wire

//--- tcl_regs_monitor.sv
// Checker of the register bank's control outputs.
// Assumes binding to the top module's ports on one clock.
`timescale 1ns/1ps
`default_nettype none
module tcl_regs_monitor (
    input wire logic       clk,               // System clock
    input wire logic       arst_n,            // Reset, active low
    input wire logic [4:0] lock_bits,         // Lock bits
    input wire logic       int_out,           // Interrupt drive value
    input wire logic       sda_out,           // Data drive value
    input wire logic       sleep_select,      // Shutdown request
    input wire logic [1:0] adc_bit_width_sel, // Resolution code
    input wire logic       conv_abort,        // Abort pulse
    input wire logic       conv_start,        // Start pulse
    input wire logic       warm_reset         // Warm reset pulse
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    a_abort_then_start: assert property (
        conv_abort |=> conv_start) else $error("no start after abort");
    a_start_after_abort: assert property (
        conv_start |-> $past(conv_abort)) else $error("start without abort");
    a_abort_one_cycle: assert property (
        conv_abort |=> !conv_abort) else $error("abort too long");
    a_warm_one_cycle: assert property (
        warm_reset |=> !warm_reset) else $error("warm reset too long");
    a_warm_aborts: assert property (
        warm_reset |-> conv_abort) else $error("warm reset without abort");
    a_warm_locked_out: assert property (
        lock_bits[4] ##1 lock_bits[4] |-> !warm_reset) else $error("locked warm reset");
    a_sleep_locked_out: assert property (
        $past(lock_bits[3]) |-> !sleep_select) else $error("shutdown under lockout");
    a_res_new_start: assert property (
        $changed(adc_bit_width_sel) |-> ##[0:3] conv_start) else $error("no restart");
    a_pins_drive_low: assert property (
        !int_out && !sda_out) else $error("pin drives high");
endmodule // tcl_regs_monitor
`default_nettype wire

//--- thermal_config_limit_regs_test.sv
// Self-checking bench of the control and limit register bank.
// Assumes the host model and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module thermal_config_limit_regs_test;
    logic       clk, arst_n, conv_done, scl, sda_low;
    logic [4:0] lock_bits;
    logic [7:0] local_temp, remote_temp;
    logic [3:0] tr;  // Remote low, diode, remote crit, local crit
    wire        sda_oe, int_oe, sleep_select;
    wire  [1:0] adc_bit_width_sel;
    wire        sda = !(sda_low | sda_oe);  // Pull-up on the data line
    int         n_mismatch = 0;
    int         comparisons = 0;
    tcl_regs u_tcl_regs (.clk, .arst_n, .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe,
        .int_out(), .int_oe, .lock_bits, .conv_done, .local_temp, .remote_temp,
        .remote_low_trip(tr[3]), .diode_fault(tr[2]), .local_crit_trip(tr[0]),
        .remote_crit_trip(tr[1]), .sleep_select, .adc_bit_width_sel, .conv_abort(),
        .conv_start(), .warm_reset());
    tcl_host u_tcl_host (.clk, .sda, .scl, .sda_low);
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic chk(input logic [7:0] s, e);
        comparisons++;
        if (s !== e) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic rc(input logic [7:0] c, e);
        logic [7:0] q;
        logic ok;
        u_tcl_host.rd(c, q, ok);
        chk(8'(ok), 8'h01);
        chk(q, e);
    endtask
    task automatic wrc(input logic [7:0] c, d);
        logic ok;
        u_tcl_host.wr(c, d, ok);
        chk(8'(ok), 8'h01);
    endtask
    // One conversion result, then time for flags and interrupt
    task automatic cv(input logic [7:0] lt, input logic [3:0] t);
        @(posedge clk) begin
            conv_done <= 1'b1;
            local_temp <= lt;
            tr <= t;
        end
        @(posedge clk) conv_done <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    task automatic dflt();
        rc(8'h03, 8'h80);
        rc(8'h04, 8'h07);
        rc(8'h05, 8'h3c);
        rc(8'h06, 8'h00);
        rc(8'h07, 8'h50);
    endtask
    task automatic t_fields();
        wrc(8'h03, 8'h3c);
        rc(8'h03, 8'h3c);
        chk(8'(adc_bit_width_sel), 8'h03);
        wrc(8'h03, 8'h40);
        chk(8'(sleep_select), 8'h01);
        for (int a = 4; a < 8; a++) begin
            wrc(8'(a), 8'h80 + 8'(a));
            rc(8'(a), 8'h80 + 8'(a));
        end
        $display("fields done");
    endtask
    task automatic t_locks();
        lock_bits <= 5'h18;
        repeat (3) @(posedge clk);
        chk(8'(sleep_select), 8'h00);
        wrc(8'h03, 8'h41);
        rc(8'h03, 8'h00);
        lock_bits <= 5'h00;
        wrc(8'h03, 8'h01);
        dflt();
        $display("locks done");
    endtask
    task automatic t_irq();
        cv(8'h00, 4'hf);
        chk(8'(int_oe), 8'h01);
        wrc(8'h03, 8'h00);
        chk(8'(int_oe), 8'h00);
        wrc(8'h03, 8'h80);
        chk(8'(int_oe), 8'h01);
        rc(8'h02, 8'h8f);
        repeat (2) @(posedge clk);
        chk(8'(int_oe), 8'h00);
        wrc(8'h04, 8'h80);
        cv(8'h00, 4'h0);
        chk(8'(int_oe), 8'h01);
        rc(8'h02, 8'h80);
        $display("irq done");
    endtask
    task automatic t_queue();
        wrc(8'h04, 8'h40);
        wrc(8'h03, 8'h90);
        cv(8'h7f, 4'h0);
        wrc(8'h03, 8'h90);
        cv(8'h7f, 4'h0);
        rc(8'h02, 8'h80);
        wrc(8'h05, 8'h3c);
        cv(8'h7f, 4'h0);
        rc(8'h02, 8'h80);
        cv(8'h7f, 4'h0);
        rc(8'h02, 8'hc0);
        $display("queue done");
    endtask
    task automatic t_reset();
        dflt();
        rc(8'h02, 8'h00);
        rc(8'h0a, 8'h00);
        $display("reset done");
    endtask
    // Negative limits: signed compare sets remote high only; critical lock
    task automatic t_signed();
        wrc(8'h03, 8'h80);
        wrc(8'h07, 8'hf6);
        wrc(8'h06, 8'hf6);
        remote_temp <= 8'h05;
        cv(8'h05, 4'h0);
        rc(8'h02, 8'h90);
        lock_bits <= 5'h01;
        wrc(8'h03, 8'h00);
        rc(8'h03, 8'h80);
        rc(8'h04, 8'h41);
        lock_bits <= 5'h00;
        $display("signed done");
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge clk);
        n_mismatch++;
        report_and_stop();
    end
    initial begin
        arst_n = 1'b0;
        conv_done = 1'b0;
        lock_bits = 5'h00;
        local_temp = 8'h00;
        remote_temp = 8'h00;
        tr = 4'h0;
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        t_reset();
        t_fields();
        t_locks();
        t_irq();
        t_queue();
        t_signed();
        report_and_stop();
    end
endmodule // thermal_config_limit_regs_test
bind tcl_regs tcl_regs_monitor u_mon (.clk, .arst_n, .lock_bits, .int_out, .sda_out,
    .sleep_select, .adc_bit_width_sel, .conv_abort, .conv_start, .warm_reset);
`default_nettype wire
